// file: hw/stc_pkg.sv
/*
  Constants and types for the state-transition and bus-sync control of the
  execute stage. Assumes a single 125 MHz system clock.
*/
package stc_pkg;
  localparam int unsigned STC_CLK_MHZ = 125;
  localparam int unsigned STC_EFFECT_DELAY = 2;   // Cycles from execute to effect
  localparam int unsigned STC_DATA_W = 32;
  localparam int unsigned STC_SEL_W = 5;
  localparam logic [31:0] STC_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] STC_IE_MASK = 32'h0000_0001;   // Interrupt-enable field of status
  localparam logic [4:0] STC_STATUS_SEL = 5'h0c;          // Status register select

  typedef enum logic [0:0] {
    STC_RUN = 1'b0,
    STC_SYNC_WAIT = 1'b1
  } stc_state_e;
endpackage : stc_pkg

// file: hw/stc_delay_line.sv
/*
  Fixed-length delay line of valid-tagged words. Assumes the caller's reset
  is already synchronised to the clock.
*/
module stc_delay_line #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data
);
  logic [DEPTH-1:0] valid_r;
  logic [WIDTH-1:0] data_r [DEPTH];

  // One stage per cycle of delay
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
          valid_r[g] <= 1'b0;
          data_r[g] <= '0;
        end else if (g == 0) begin
          valid_r[g] <= i_valid;
          data_r[g] <= i_data;
        end else begin
          valid_r[g] <= valid_r[(g == 0) ? 0 : g-1];
          data_r[g] <= data_r[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  assign o_valid = valid_r[DEPTH-1];
  assign o_data = data_r[DEPTH-1];
endmodule : stc_delay_line

// file: hw/stc_sync_ctrl.sv
/*
  Execute-stage control for interrupt enable/disable, coprocessor register
  writes, standby entry and the bus-synchronising instruction. Assumes the
  instruction arrives decoded as one-cycle execute pulses, and that the bus
  and write buffer report idle and empty on the same clock.
*/
module stc_sync_ctrl #(
  parameter int unsigned DELAY = stc_pkg::STC_EFFECT_DELAY
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_interrupt_enable_instr,
  input wire logic i_interrupt_disable_instr,
  input wire logic i_coproc_register_write_instr,
  input wire logic [stc_pkg::STC_SEL_W-1:0] i_cop_sel,
  input wire logic [stc_pkg::STC_DATA_W-1:0] i_cop_wdata,
  input wire logic i_standby_instr,
  input wire logic i_sync_instr,
  input wire logic i_patch_reg_write,
  input wire logic i_wbuf_empty,
  input wire logic i_bus_busy,
  output logic o_stall,
  output logic o_fetch_hold,
  output logic o_int_accept_en,
  output logic o_cop_we,
  output logic [stc_pkg::STC_SEL_W-1:0] o_cop_sel,
  output logic [stc_pkg::STC_DATA_W-1:0] o_cop_wdata,
  output logic [stc_pkg::STC_DATA_W-1:0] o_status,
  output logic o_standby
);
  import stc_pkg::*;

  localparam int unsigned CMD_W = 2 + STC_SEL_W + STC_DATA_W;

  logic rst_meta_r;
  logic rst_sync_r;
  logic rstn;
  stc_state_e state_r;
  stc_state_e state_nxt;
  logic patch_pend_r;
  logic drained;
  logic held_cop_r;
  logic held_stby_r;
  logic [STC_SEL_W-1:0] held_sel_r;
  logic [STC_DATA_W-1:0] held_data_r;
  logic issue_cop;
  logic issue_stby;
  logic [STC_SEL_W-1:0] issue_sel;
  logic [STC_DATA_W-1:0] issue_data;
  logic dis_now;
  logic dly_valid;
  logic [CMD_W-1:0] dly_in;
  logic [CMD_W-1:0] dly_out;
  logic ie_dly_valid;
  logic [0:0] ie_dly_out;
  logic dly_cop;
  logic dly_stby;
  logic [STC_SEL_W-1:0] dly_sel;
  logic [STC_DATA_W-1:0] dly_data;
  logic status_ie_nxt;
  logic int_block_r;
  logic [STC_DATA_W-1:0] status_r;

  // Reset released through two flops so all flops leave reset together
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rstn = rst_sync_r;

  // Bus quiet: nothing in the write buffer and no cycle outstanding
  assign drained = i_wbuf_empty && !i_bus_busy;

  // Sync state: entered by the sync instruction unless already drained
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      STC_RUN: begin
        if (i_sync_instr && !drained) begin
          state_nxt = STC_SYNC_WAIT;
        end
      end
      STC_SYNC_WAIT: begin
        if (drained) begin
          state_nxt = STC_RUN;
        end
      end
      default: state_nxt = STC_RUN;
    endcase
  end

  always_ff @(posedge i_clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= STC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // A patch-region write followed by sync holds fetch until drained
  always_ff @(posedge i_clock or negedge rstn) begin
    if (!rstn) begin
      patch_pend_r <= 1'b0;
    end else if (i_patch_reg_write) begin
      patch_pend_r <= 1'b1;  // Set wins over drain in the same cycle
    end else if (drained) begin
      patch_pend_r <= 1'b0;
    end
  end

  // A coprocessor write or standby arriving during the sync wait is parked
  // here; the pipeline is stalled so at most one can be pending.
  always_ff @(posedge i_clock or negedge rstn) begin
    if (!rstn) begin
      held_cop_r <= 1'b0;
      held_stby_r <= 1'b0;
      held_sel_r <= '0;
      held_data_r <= '0;
    end else if (state_r == STC_SYNC_WAIT && !drained) begin
      if (i_coproc_register_write_instr) begin
        held_cop_r <= 1'b1;
        held_sel_r <= i_cop_sel;
        held_data_r <= i_cop_wdata;
      end
      if (i_standby_instr) begin
        held_stby_r <= 1'b1;
      end
    end else begin
      held_cop_r <= 1'b0;
      held_stby_r <= 1'b0;
    end
  end

  // Issue now unless sync is waiting; outside a sync, no bus wait at all
  always_comb begin
    issue_cop = 1'b0;
    issue_stby = 1'b0;
    issue_sel = i_cop_sel;
    issue_data = i_cop_wdata;
    if (state_r == STC_RUN) begin
      issue_cop = i_coproc_register_write_instr;
      issue_stby = i_standby_instr;
    end else if (drained) begin
      issue_cop = held_cop_r || i_coproc_register_write_instr;
      issue_stby = held_stby_r || i_standby_instr;
      if (held_cop_r) begin
        issue_sel = held_sel_r;
        issue_data = held_data_r;
      end
    end
  end

  // Immediate block: disable instruction, or a status write clearing enable
  assign dis_now = i_interrupt_disable_instr
    || (issue_cop && issue_sel == STC_STATUS_SEL && (issue_data & STC_IE_MASK) == '0);

  assign dly_in = {issue_cop, issue_stby, issue_sel, issue_data};
  assign dly_valid = issue_cop || issue_stby;

  // Two-cycle path for coprocessor writes and standby entry
  stc_delay_line #(
    .WIDTH(CMD_W),
    .DEPTH(DELAY)
  ) u_cmd_delay (
    .i_clock(i_clock),
    .i_rstn(rstn),
    .i_valid(dly_valid),
    .i_data(dly_in),
    .o_valid(),
    .o_data(dly_out)
  );

  assign dly_cop = dly_out[CMD_W-1];
  assign dly_stby = dly_out[CMD_W-2];
  assign dly_sel = dly_out[STC_DATA_W +: STC_SEL_W];
  assign dly_data = dly_out[STC_DATA_W-1:0];

  // Separate delay for enable/disable instructions acting on status
  stc_delay_line #(
    .WIDTH(1),
    .DEPTH(DELAY)
  ) u_ie_delay (
    .i_clock(i_clock),
    .i_rstn(rstn),
    .i_valid(i_interrupt_enable_instr || i_interrupt_disable_instr),
    .i_data(i_interrupt_enable_instr),
    .o_valid(ie_dly_valid),
    .o_data(ie_dly_out)
  );

  // Status enable bit lands two cycles after the instruction
  always_comb begin
    status_ie_nxt = status_r[0];
    if (dly_cop && dly_sel == STC_STATUS_SEL) begin
      status_ie_nxt = dly_data[0];
    end
    if (ie_dly_valid) begin
      status_ie_nxt = ie_dly_out[0];
    end
  end

  always_ff @(posedge i_clock or negedge rstn) begin
    if (!rstn) begin
      status_r <= STC_STATUS_RST;
    end else begin
      if (dly_cop && dly_sel == STC_STATUS_SEL) begin
        status_r <= dly_data;
      end
      status_r[0] <= status_ie_nxt;
    end
  end

  // Block holds from the disabling cycle until the next delayed enable/disable or status write; an enable issued
  // the cycle before the disable lands first, clears it, and lets acceptance through for one cycle.
  always_ff @(posedge i_clock or negedge rstn) begin
    if (!rstn) begin
      int_block_r <= 1'b0;
    end else if (dis_now) begin
      int_block_r <= 1'b1;
    end else if (ie_dly_valid || (dly_cop && dly_sel == STC_STATUS_SEL)) begin
      int_block_r <= 1'b0;
    end
  end

  // Registered outputs; acceptance gated by the registered block as well
  always_ff @(posedge i_clock or negedge rstn) begin
    if (!rstn) begin
      o_int_accept_en <= 1'b0;
      o_cop_we <= 1'b0;
      o_cop_sel <= '0;
      o_cop_wdata <= '0;
      o_status <= STC_STATUS_RST;
      o_standby <= 1'b0;
      o_stall <= 1'b0;
      o_fetch_hold <= 1'b0;
    end else begin
      o_int_accept_en <= status_ie_nxt && !dis_now && !(int_block_r && !ie_dly_valid
        && !(dly_cop && dly_sel == STC_STATUS_SEL));
      o_cop_we <= dly_cop;
      o_cop_sel <= dly_sel;
      o_cop_wdata <= dly_data;
      o_status[STC_DATA_W-1:1] <= (dly_cop && dly_sel == STC_STATUS_SEL) ?
        dly_data[STC_DATA_W-1:1] : status_r[STC_DATA_W-1:1];
      o_status[0] <= status_ie_nxt;
      o_standby <= dly_stby || (o_standby && !i_interrupt_enable_instr);
      o_stall <= (state_nxt == STC_SYNC_WAIT);
      o_fetch_hold <= (state_nxt == STC_SYNC_WAIT) && (patch_pend_r || i_patch_reg_write);
    end
  end
endmodule : stc_sync_ctrl

// file: testbench/stc_sync_checker.sv
/*
  Port checker for stc_sync_ctrl.
  Assumes the bench keeps the legal instruction order.
*/
module stc_sync_checker (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_interrupt_enable_instr,
  input wire logic i_interrupt_disable_instr,
  input wire logic i_coproc_register_write_instr,
  input wire logic [stc_pkg::STC_SEL_W-1:0] i_cop_sel,
  input wire logic [stc_pkg::STC_DATA_W-1:0] i_cop_wdata,
  input wire logic i_standby_instr,
  input wire logic i_sync_instr,
  input wire logic i_patch_reg_write,
  input wire logic i_wbuf_empty,
  input wire logic i_bus_busy,
  input wire logic o_stall,
  input wire logic o_fetch_hold,
  input wire logic o_int_accept_en,
  input wire logic o_cop_we,
  input wire logic [stc_pkg::STC_DATA_W-1:0] o_status,
  input wire logic o_standby
);
  import stc_pkg::*;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  // Short aliases; drained means buffer empty and bus idle
  wire logic en = i_interrupt_enable_instr;
  wire logic dis = i_interrupt_disable_instr;
  wire logic cw = i_coproc_register_write_instr;
  wire logic drained = i_wbuf_empty && !i_bus_busy;
  // Enable or disable, then two quiet cycles
  sequence en_s;
    en && !o_int_accept_en ##1 (!(dis || cw))[*2];
  endsequence
  sequence dis_s;
    dis && o_status[0] ##1 (!en)[*2];
  endsequence
  // Patch-register store, then sync before the write buffer and bus have drained
  sequence patch_s;
    i_patch_reg_write ##1 (i_sync_instr && !drained);
  endsequence
  chk_enable_late: assert property (en_s |-> !o_int_accept_en ##1 o_int_accept_en)
    else $error("enable took effect at wrong cycle");
  chk_disable_now: assert property (dis |=> !o_int_accept_en)
    else $error("disable not immediate");
  chk_status_late: assert property (dis_s |-> o_status[0] ##1 !o_status[0])
    else $error("status bit cleared at wrong cycle");
  chk_cop_late: assert property (cw && !o_stall |-> ##3 o_cop_we)
    else $error("coprocessor write late");
  chk_cop_dis: assert property (cw && !o_stall && i_cop_sel == STC_STATUS_SEL && !i_cop_wdata[0]
    |=> !o_int_accept_en)
    else $error("status write did not disable at once");
  chk_stby_late: assert property (i_standby_instr && !o_stall && !o_standby
    |-> !o_standby[*3] ##1 o_standby)
    else $error("standby entered at wrong cycle");
  chk_sync_hold: assert property (i_sync_instr && !drained |=> o_stall)
    else $error("sync did not stall");
  chk_stall_keep: assert property (o_stall && !drained |=> o_stall)
    else $error("stall left before drain");
  chk_stall_free: assert property (o_stall && drained |=> !o_stall)
    else $error("stall kept after drain");
  chk_parked_quiet: assert property (o_stall[*3] |-> !o_cop_we && !$rose(o_standby))
    else $error("parked operation leaked during stall");
  chk_fetch_hold: assert property (o_fetch_hold |-> o_stall)
    else $error("fetch held without sync wait");
  chk_fetch_patch: assert property (patch_s |=> o_fetch_hold)
    else $error("fetch not held after patch write");
endmodule : stc_sync_checker
bind stc_sync_ctrl stc_sync_checker u_stc_sync_checker (.*);

// file: testbench/stc_bus_model.sv
/*
  Bus and write-buffer model at the far side.
  Assumes stores arrive as one-cycle pulses.
*/
module stc_bus_model (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_store,
  input wire logic [3:0] i_lat,
  output logic o_wbuf_empty,
  output logic o_bus_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int pend;
  int cnt;
  // One store on the bus at a time; latency set per store, so completion is unpredictable
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pend = 0;
      cnt = 0;
    end else begin
      if (cnt > 0) cnt = cnt - 1;
      else if (pend > 0) begin
        pend = pend - 1;
        cnt = i_lat;
      end
      if (i_store) pend = pend + 1;
    end
    o_wbuf_empty <= (pend == 0);
    o_bus_busy <= (cnt > 0);
  end
endmodule : stc_bus_model

// file: testbench/tb_stc_sync_ctrl.sv
/*
  Self-checking bench for stc_sync_ctrl.
  Assumes an 8 ns clock; inputs change at the falling edge.
*/
module tb_stc_sync_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import stc_pkg::*;
  logic i_clock = 0;
  logic i_rstn = 0;
  logic [6:0] ins = '0; // en dis cop stby sync patch store
  logic [4:0] sel = '0;
  logic [31:0] wd = '0;
  logic [3:0] lat = 4'h3;
  logic stall, fhold, acc, we, stby, wbe, busy;
  logic [4:0] osel;
  logic [31:0] owd, st;
  logic [36:0] exp_q[$];
  int failures = 0;
  int n_checks = 0;
  int seed = 32'hd231;
  int i;
  int d;
  // Design and far-side model
  stc_sync_ctrl u_stc_sync_ctrl (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_interrupt_enable_instr(ins[0]), .i_interrupt_disable_instr(ins[1]),
    .i_coproc_register_write_instr(ins[2]), .i_cop_sel(sel), .i_cop_wdata(wd),
    .i_standby_instr(ins[3]), .i_sync_instr(ins[4]), .i_patch_reg_write(ins[5]),
    .i_wbuf_empty(wbe), .i_bus_busy(busy), .o_stall(stall), .o_fetch_hold(fhold),
    .o_int_accept_en(acc), .o_cop_we(we), .o_cop_sel(osel), .o_cop_wdata(owd),
    .o_status(st), .o_standby(stby));
  stc_bus_model u_stc_bus_model (.i_clock(i_clock), .i_rstn(i_rstn), .i_store(ins[6]),
    .i_lat(lat), .o_wbuf_empty(wbe), .o_bus_busy(busy));
  // Clock
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  task automatic chk(input string nm, input logic [36:0] seen, input logic [36:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One-cycle execute pulse; returns half a cycle after its edge
  task automatic issue(input int k);
    ins[k] = 1'b1;
    @(negedge i_clock);
    ins[k] = 1'b0;
  endtask : issue
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clock);
  endtask : wait_n
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // Store, then sync instead of idle padding k is parked behind it
  task automatic sync_run(input int k, input int pw);
    lat = 4'($unsigned($random(seed)) % 9 + 4);
    ins[6] = 1'b1;
    ins[5] = pw[0];
    @(negedge i_clock);
    ins = '0;
    issue(4);
    chk("stall", stall, 1);
    if (k >= 0) ins[k] = 1'b1;
    for (i = 0; i < 40 && stall === 1'b1; i++) begin
      d = wbe & ~busy;
      chk("fetch_hold", fhold, pw[0]);
      chk("cop_we", we, 0);
      @(negedge i_clock);
      ins = '0;
      chk("stall", stall, !d);
    end
    chk("stall", stall, 0);
    chk("fetch_hold", fhold, 0);
    for (i = 0; i < 6 && (we | stby) !== 1'b1; i++) @(negedge i_clock);
  endtask : sync_run
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #(8 * 5000);
    failures++;
    end_sim();
  end
  // Main sequence
  initial begin
    wait_n(3);
    i_rstn = 1'b1;
    wait_n(3);
    chk("status", st, STC_STATUS_RST);
    chk("accept", acc, 0);
    $display("test reset done");
    lat = 4'hf;
    issue(6);
    issue(0);
    chk("accept", acc, 0);
    wait_n(1);
    chk("accept", acc, 0);
    wait_n(1);
    chk("accept", acc, 1);
    chk("status", st, STC_IE_MASK);
    issue(1);
    chk("accept", acc, 0);
    chk("status", st, STC_IE_MASK);
    wait_n(2);
    chk("status", st, 0);
    $display("test enable disable done");
    for (int j = 0; j < 5; j++) begin
      sel = 5'($random(seed));
      if (sel == STC_STATUS_SEL) sel = 5'h01;
      wd = $random(seed);
      if (j == 4) begin
        issue(0);
        wait_n(2);
        sel = STC_STATUS_SEL;
        wd = '0;
      end
      exp_q.push_back({sel, wd});
      issue(2);
      if (j == 4) chk("accept", acc, 0);
      chk("cop_we", we, 0);
      wait_n(2);
      chk("cop_we", we, 1);
      chk("cop_write", {osel, owd}, exp_q.pop_front());
    end
    $display("test coprocessor write done");
    issue(6);
    issue(3);
    chk("standby", stby, 0);
    wait_n(1);
    chk("standby", stby, 0);
    wait_n(1);
    chk("standby", stby, 1);
    issue(0);
    chk("standby", stby, 0);
    wait_n(3);
    sel = 5'h02;
    wd = $random(seed);
    exp_q.push_back({sel, wd});
    sync_run(2, 0);
    chk("cop_we", we, 1);
    chk("cop_write", {osel, owd}, exp_q.pop_front());
    sync_run(3, 0);
    chk("standby", stby, 1);
    issue(0);
    wait_n(3);
    for (int j = 0; j < 3; j++) sync_run(-1, 1);
    $display("test sync done");
    end_sim();
  end
endmodule : tb_stc_sync_ctrl
